// ---- rtl/itld_regs.vh ----
// Purpose: Constants for the isochronous transmit end-command decoder.
// Assumes: Included by the decoder files by its bare name.
// Notes: Byte offsets are Avalon byte addresses of 32-bit registers.
`ifndef ITLD_REGS_VH
`define ITLD_REGS_VH
// ============================================================
// Register offsets
`define ITLD_OFS_CTRL 5'h00
`define ITLD_OFS_STAT 5'h04
`define ITLD_OFS_MASK 5'h08
`define ITLD_OFS_NEXT 5'h0c
`define ITLD_OFS_STATE 5'h10
// ============================================================
// Reset values
`define ITLD_RST_CTRL 1'h0
`define ITLD_RST_MASK 4'h0
// ============================================================
// Status and mask bit positions
`define ITLD_EV_DONE 0
`define ITLD_EV_STOP 1
`define ITLD_EV_MISS 2
`define ITLD_EV_BAD 3
// ============================================================
// Command word fields
`define ITLD_CMD_HI 31
`define ITLD_CMD_LO 28
`define ITLD_S_BIT 27
`define ITLD_KEY_HI 26
`define ITLD_KEY_LO 24
`define ITLD_I_HI 21
`define ITLD_I_LO 20
`define ITLD_B_HI 19
`define ITLD_B_LO 18
`define ITLD_LEN_HI 15
`define ITLD_LEN_LO 0
// ============================================================
// Encodings
`define ITLD_OP_LAST 4'h1
`define ITLD_OP_MARK 4'h8
`define ITLD_KEY_FRAG 3'h0
`define ITLD_KEY_HDR 3'h1
`define ITLD_IRQ_ON 2'h3
`define ITLD_BR_ALWAYS 2'h3
`define ITLD_HDR_LEN 16'h0008
`define ITLD_STEP_STD 6'h10
`define ITLD_STEP_IMM 6'h20
`define ITLD_CNT_STOP 4'h0
`endif

// ---- rtl/itld_cq_pack.v ----
// Purpose: Packs the completion quadlet of an end descriptor.
// Assumes: Inputs are stable registered values.
// Notes: Purely combinational.
`include "itld_regs.vh"
module itld_cq_pack (
  input wire [15:0] status_word,
  input wire [2:0] secs_low,
  input wire [12:0] ticks,
  output wire [31:0] quadlet
);
  // ============================================================
  // Packing
  assign quadlet = {status_word, secs_low, ticks}; // RQ9 RQ10 RQ19
endmodule // itld_cq_pack

// ---- rtl/itld_decode.v ----
// Purpose: Decodes and runs end and marker command descriptors.
// Assumes: A fetcher presents whole descriptors; one clock domain.
// Notes: Registers are reached over Avalon-MM with waitrequest.
//
// Notes on behaviour
// RQ1: Opcode 4'h1 with subtype 3'b000 supplies last data fragment, ends packet.
// RQ2: Status and cycle stamp are written only when status_write_flag is one.
// RQ3: irq_select 2'b11 raises the done interrupt; 2'b00 raises none.
// RQ4: End commands branch to next_block_pointer; software sets branch_select 2'b11.
// RQ5: Data end command fetches byte_length bytes from buffer_pointer.
// RQ6: Next descriptor address is the 28-bit pointer shifted to 16-byte units.
// RQ7: Missed cycle continues at missed_cycle_pointer from block's first descriptor.
// RQ8: Block count zero in an end command stops the context.
// RQ9: completion_status takes bits 15:0 of channel_ctrl_word.
// RQ10: Cycle stamp holds three seconds bits and thirteen tick bits.
// RQ11: Subtype 3'b001 is the header-only end command, byte_length 16'h0008.
// RQ12: Header-only command sends its first two immediate quadlets as header.
// RQ13: Header-only command occupies 32 bytes of descriptor memory.
// RQ14: Software uses header-only end commands only for zero-data packets.
// RQ15: Marker command writes one quadlet to buffer_pointer.
// RQ16: Software places at most one marker, first in its block.
// RQ17: Opcode 4'h8 is decoded as a memory store, not a fragment.
// RQ18: Marker quadlet is the 16-bit value zero-extended, quadlet aligned.
// RQ19: Status upper half, stamp lower half, written as one quadlet store.
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`include "itld_regs.vh"
module itld_decode (
  input wire clk_sys,
  input wire rst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq,
  input wire desc_valid,
  input wire [31:0] desc_addr,
  input wire desc_first,
  input wire [31:0] desc_q0,
  input wire [31:0] desc_q1,
  input wire [31:0] desc_q2,
  input wire [31:0] desc_q3,
  input wire [31:0] desc_imm0,
  input wire [31:0] desc_imm1,
  output reg desc_ready,
  output reg [5:0] desc_step,
  input wire missed_cycle,
  input wire [15:0] channel_ctrl_word,
  input wire [6:0] bus_time_seconds,
  input wire [12:0] bus_time_ticks,
  output reg buf_rd_req,
  output reg [31:0] buf_rd_addr,
  output reg [15:0] buf_rd_len,
  input wire buf_rd_done,
  output reg hdr_valid,
  output reg [31:0] hdr_q0,
  output reg [31:0] hdr_q1,
  output reg pkt_end,
  output reg mem_wr_req,
  output reg [31:0] mem_wr_addr,
  output reg [31:0] mem_wr_data,
  input wire mem_wr_ack,
  output reg next_valid,
  output reg [31:0] next_addr,
  output reg [3:0] next_count,
  output reg ctx_stop,
  output reg tx_done_irq
);
  // ============================================================
  // States
  localparam S_IDLE = 7'b0000001;
  localparam S_DEC = 7'b0000010;
  localparam S_FETCH = 7'b0000100;
  localparam S_HDR = 7'b0001000;
  localparam S_STAT = 7'b0010000;
  localparam S_MARK = 7'b0100000;
  localparam S_NEXT = 7'b1000000;

  // ============================================================
  // Functions
  function [31:0] blk_addr;
    input [31:0] ptr_word;
    begin
      blk_addr = {ptr_word[31:4], 4'h0}; // RQ6 RQ7
    end
  endfunction

  function [31:0] be_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer k;
    begin
      be_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          be_merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  // ============================================================
  // Storage
  reg [6:0] state_ff;
  reg [6:0] nxt_state;
  reg [31:0] q0_ff;
  reg [31:0] q1_ff;
  reg [31:0] q2_ff;
  reg [31:0] addr_ff;
  reg [31:0] skip_ff;
  reg ctrl_run_ff;
  reg [3:0] stat_ff;
  reg [3:0] mask_ff;
  reg [15:0] cstat_ff;
  reg [2:0] csec_ff;
  reg [12:0] ctick_ff;
  reg [3:0] ev;
  wire [31:0] cq_word;
  wire [3:0] op = q0_ff[`ITLD_CMD_HI:`ITLD_CMD_LO];
  wire [2:0] subtype = q0_ff[`ITLD_KEY_HI:`ITLD_KEY_LO];
  wire swf = q0_ff[`ITLD_S_BIT];
  wire [1:0] isel = q0_ff[`ITLD_I_HI:`ITLD_I_LO];
  wire is_end = (op == `ITLD_OP_LAST) &&
    (subtype == `ITLD_KEY_FRAG || subtype == `ITLD_KEY_HDR); // RQ1 RQ11
  wire is_hdr = (subtype == `ITLD_KEY_HDR); // RQ11
  wire is_mark = (op == `ITLD_OP_MARK); // RQ17
  wire bus_acc = (avs_read || avs_write) && avs_waitrequest;
  wire wr_now = avs_write && !avs_waitrequest;
  wire [31:0] mask_wr = be_merge({28'h000_0000, mask_ff},
    avs_writedata, avs_byteenable);
  wire [31:0] stat_clr = be_merge(32'h0000_0000, avs_writedata,
    avs_byteenable);

  itld_cq_pack u_pack (
    .status_word(cstat_ff),
    .secs_low(csec_ff),
    .ticks(ctick_ff),
    .quadlet(cq_word)
  );

  // ============================================================
  // Sequencer
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (ctrl_run_ff && missed_cycle) begin
          nxt_state = S_NEXT;
        end else if (ctrl_run_ff && desc_valid) begin
          nxt_state = S_DEC;
        end
      end
      S_DEC: begin
        if (is_mark) begin
          nxt_state = S_MARK;
        end else if (is_end && is_hdr) begin
          nxt_state = S_HDR;
        end else if (is_end) begin
          nxt_state = S_FETCH;
        end else begin
          nxt_state = S_IDLE;
        end
      end
      S_FETCH: begin
        if (buf_rd_done) begin
          nxt_state = swf ? S_STAT : S_NEXT; // RQ2
        end
      end
      S_HDR: begin
        nxt_state = swf ? S_STAT : S_NEXT; // RQ2
      end
      S_STAT: begin
        if (mem_wr_ack) begin
          nxt_state = S_NEXT;
        end
      end
      S_MARK: begin
        if (mem_wr_ack) begin
          nxt_state = S_IDLE;
        end
      end
      S_NEXT: begin
        nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      q0_ff <= 32'h0000_0000;
      q1_ff <= 32'h0000_0000;
      q2_ff <= 32'h0000_0000;
      addr_ff <= 32'h0000_0000;
      skip_ff <= 32'h0000_0000;
      desc_ready <= 1'b0;
      desc_step <= 6'h00;
      buf_rd_req <= 1'b0;
      buf_rd_addr <= 32'h0000_0000;
      buf_rd_len <= 16'h0000;
      hdr_valid <= 1'b0;
      hdr_q0 <= 32'h0000_0000;
      hdr_q1 <= 32'h0000_0000;
      pkt_end <= 1'b0;
      mem_wr_req <= 1'b0;
      mem_wr_addr <= 32'h0000_0000;
      mem_wr_data <= 32'h0000_0000;
      next_valid <= 1'b0;
      next_addr <= 32'h0000_0000;
      next_count <= 4'h0;
      ctx_stop <= 1'b0;
      tx_done_irq <= 1'b0;
      cstat_ff <= 16'h0000;
      csec_ff <= 3'h0;
      ctick_ff <= 13'h000;
      ev <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      desc_ready <= 1'b0;
      hdr_valid <= 1'b0;
      pkt_end <= 1'b0;
      next_valid <= 1'b0;
      ctx_stop <= 1'b0;
      tx_done_irq <= 1'b0;
      ev <= 4'h0;
      case (state_ff)
        S_IDLE: begin
          if (ctrl_run_ff && missed_cycle) begin
            ev[`ITLD_EV_MISS] <= 1'b1;
            q2_ff <= skip_ff; // RQ7
          end else if (ctrl_run_ff && desc_valid) begin
            q0_ff <= desc_q0;
            q1_ff <= desc_q1;
            q2_ff <= desc_q2;
            addr_ff <= desc_addr;
            if (desc_first) begin
              skip_ff <= desc_q2; // RQ7
            end
            desc_ready <= 1'b1;
            if (desc_q0[`ITLD_CMD_HI:`ITLD_CMD_LO] == `ITLD_OP_LAST &&
                desc_q0[`ITLD_KEY_HI:`ITLD_KEY_LO] == `ITLD_KEY_HDR) begin
              desc_step <= `ITLD_STEP_IMM; // RQ13
            end else begin
              desc_step <= `ITLD_STEP_STD;
            end
            hdr_q0 <= desc_imm0; // RQ12
            hdr_q1 <= desc_imm1; // RQ12
          end
        end
        S_DEC: begin
          if (is_mark) begin
            mem_wr_req <= 1'b1;
            mem_wr_addr <= {q1_ff[31:2], 2'b00}; // RQ15 RQ18
            mem_wr_data <= {16'h0000,
              q0_ff[`ITLD_LEN_HI:`ITLD_LEN_LO]}; // RQ18
          end else if (is_end && !is_hdr) begin
            buf_rd_req <= 1'b1; // RQ5
            buf_rd_addr <= q1_ff; // RQ5
            buf_rd_len <= q0_ff[`ITLD_LEN_HI:`ITLD_LEN_LO]; // RQ5
          end else if (!is_end) begin
            ev[`ITLD_EV_BAD] <= 1'b1;
          end
        end
        S_FETCH: begin
          if (buf_rd_done) begin
            buf_rd_req <= 1'b0;
            pkt_end <= 1'b1; // RQ1
            cstat_ff <= channel_ctrl_word; // RQ9
            csec_ff <= bus_time_seconds[2:0]; // RQ10
            ctick_ff <= bus_time_ticks; // RQ10
          end
        end
        S_HDR: begin
          hdr_valid <= 1'b1; // RQ12
          pkt_end <= 1'b1;
          cstat_ff <= channel_ctrl_word; // RQ9
          csec_ff <= bus_time_seconds[2:0]; // RQ10
          ctick_ff <= bus_time_ticks; // RQ10
        end
        S_STAT: begin
          // The pack unit reads the stamp captured one state earlier.
          mem_wr_req <= ~mem_wr_ack; // RQ2
          mem_wr_addr <= addr_ff + 32'h0000_000c; // RQ19
          mem_wr_data <= cq_word; // RQ19
        end
        S_MARK: begin
          if (mem_wr_ack) begin
            mem_wr_req <= 1'b0;
          end
        end
        S_NEXT: begin
          mem_wr_req <= 1'b0;
          next_addr <= blk_addr(q2_ff); // RQ4 RQ6
          next_count <= q2_ff[3:0];
          if (q2_ff[3:0] == `ITLD_CNT_STOP) begin
            ctx_stop <= 1'b1; // RQ8
            ev[`ITLD_EV_STOP] <= 1'b1;
          end else begin
            next_valid <= 1'b1;
          end
          if (is_end && isel == `ITLD_IRQ_ON &&
              !ev[`ITLD_EV_MISS]) begin
            tx_done_irq <= 1'b1; // RQ3
            ev[`ITLD_EV_DONE] <= 1'b1;
          end
        end
        default: begin
          mem_wr_req <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // Register slave
  // A new event wins over a write-one-to-clear in the same cycle.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_run_ff <= `ITLD_RST_CTRL;
      stat_ff <= 4'h0;
      mask_ff <= `ITLD_RST_MASK;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      avs_waitrequest <= ~bus_acc;
      if (bus_acc && avs_read) begin
        case (avs_address)
          `ITLD_OFS_CTRL: avs_readdata <= {31'h000_0000, ctrl_run_ff};
          `ITLD_OFS_STAT: avs_readdata <= {28'h000_0000, stat_ff};
          `ITLD_OFS_MASK: avs_readdata <= {28'h000_0000, mask_ff};
          `ITLD_OFS_NEXT: avs_readdata <= next_addr;
          `ITLD_OFS_STATE: avs_readdata <= {25'h00_0000, state_ff};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (wr_now && avs_address == `ITLD_OFS_CTRL && avs_byteenable[0]) begin
        ctrl_run_ff <= avs_writedata[0];
      end else if (ev[`ITLD_EV_STOP]) begin
        ctrl_run_ff <= 1'b0; // RQ8
      end
      if (wr_now && avs_address == `ITLD_OFS_MASK) begin
        mask_ff <= mask_wr[3:0];
      end
      if (wr_now && avs_address == `ITLD_OFS_STAT) begin
        stat_ff <= (stat_ff & ~stat_clr[3:0]) | ev;
      end else begin
        stat_ff <= stat_ff | ev;
      end
      irq <= |(stat_ff & mask_ff);
    end
  end
endmodule // itld_decode

// ---- dv/itld_host_mem.sv ----
// Purpose: Host memory model for buffer reads and quadlet stores.
// Assumes: Requests are held until answered.
// Notes: The slow input adds five wait cycles to every answer.
module itld_host_mem (
  input wire clk_sys,
  input wire rst_n,
  input wire slow,
  input wire buf_rd_req,
  input wire mem_wr_req,
  input wire [31:0] mem_wr_addr,
  input wire [31:0] mem_wr_data,
  output logic buf_rd_done,
  output logic mem_wr_ack,
  output logic [31:0] last_addr,
  output logic [31:0] last_data,
  output logic [7:0] wr_total
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_ff;
  // ==========================================
  // Answers
  // The answer gate stops a held request from being served twice.
  always @(posedge clk_sys) begin
    buf_rd_done <= 1'b0;
    mem_wr_ack <= 1'b0;
    if (!rst_n) begin
      wait_ff <= 4'h0;
      wr_total <= 8'h00;
    end else if ((buf_rd_req | mem_wr_req) & ~buf_rd_done & ~mem_wr_ack) begin
      if (wait_ff != {1'b0, slow, 1'b0, slow}) begin
        wait_ff <= wait_ff + 4'h1;
      end else begin
        wait_ff <= 4'h0;
        buf_rd_done <= buf_rd_req;
        mem_wr_ack <= mem_wr_req;
        if (mem_wr_req) begin
          last_addr <= mem_wr_addr;
          last_data <= mem_wr_data;
          wr_total <= wr_total + 8'h01;
        end
      end
    end
  end
endmodule // itld_host_mem

// ---- dv/itld_decode_checker.sv ----
// Purpose: Timing relations of the end-command decoder ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to every decoder instance.
module itld_decode_checker (
  input wire clk_sys,
  input wire rst_n,
  input wire [31:0] desc_q0,
  input wire desc_ready,
  input wire [5:0] desc_step,
  input wire buf_rd_req,
  input wire [31:0] buf_rd_addr,
  input wire [15:0] buf_rd_len,
  input wire buf_rd_done,
  input wire hdr_valid,
  input wire pkt_end,
  input wire mem_wr_req,
  input wire [31:0] mem_wr_addr,
  input wire [31:0] mem_wr_data,
  input wire mem_wr_ack,
  input wire next_valid,
  input wire [31:0] next_addr,
  input wire ctx_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Assertions
  a_step_size: assert property (
    desc_ready |-> desc_step == (($past(desc_q0[31:24]) & 8'hf7) == 8'h11
      ? 6'h20 : 6'h10)) else $error("descriptor step wrong");
  a_mark_data: assert property (
    desc_ready && $past(desc_q0[31:28]) == 4'h8 |=> mem_wr_req
      && mem_wr_data == {16'h0000, $past(desc_q0[15:0], 2)})
    else $error("marker store wrong");
  a_mark_nofrag: assert property (
    desc_ready && $past(desc_q0[31:28]) == 4'h8 |=> !pkt_end [*3])
    else $error("marker ended a packet");
  a_wr_align: assert property (
    mem_wr_req |-> mem_wr_addr[1:0] == 2'b00) else $error("store misaligned");
  a_rd_hold: assert property (
    buf_rd_req && !buf_rd_done |=> buf_rd_req && $stable(buf_rd_addr)
      && $stable(buf_rd_len)) else $error("buffer read dropped");
  a_wr_hold: assert property (
    mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable(mem_wr_addr)
      && $stable(mem_wr_data)) else $error("store dropped");
  a_rd_end: assert property (
    buf_rd_req && buf_rd_done |=> pkt_end && !buf_rd_req)
    else $error("no packet end after data");
  a_hdr_end: assert property (
    hdr_valid |-> pkt_end) else $error("header without packet end");
  a_next_align: assert property (
    next_valid |-> next_addr[3:0] == 4'h0) else $error("next misaligned");
  c_hdr: cover property (hdr_valid);
  c_stop: cover property (ctx_stop);
  c_store: cover property (mem_wr_req && mem_wr_ack);
endmodule // itld_decode_checker
bind itld_decode itld_decode_checker i_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .desc_q0(desc_q0), .desc_ready(desc_ready),
  .desc_step(desc_step), .buf_rd_req(buf_rd_req), .buf_rd_addr(buf_rd_addr),
  .buf_rd_len(buf_rd_len), .buf_rd_done(buf_rd_done), .hdr_valid(hdr_valid),
  .pkt_end(pkt_end), .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr),
  .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack),
  .next_valid(next_valid), .next_addr(next_addr), .ctx_stop(ctx_stop));

// ---- dv/itld_decode_test.sv ----
// Purpose: Self-checking bench for the end-command decoder.
// Assumes: The host memory model answers promptly or slowly.
// Notes: Table rows first, then interrupt, stop and missed-cycle cases.
module itld_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] q0, q1, q2, wa, wd;
    logic [5:0] step;
    logic [7:0] wr;
  } itld_row_t;
  logic clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0, slow = 0;
  logic desc_valid = 0, desc_first = 0, missed_cycle = 0, is_mark = 0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 0, desc_addr = 0, desc_imm0 = 0;
  logic [31:0] desc_q0 = 0, desc_q1 = 0, desc_q2 = 0, desc_imm1 = 0, q;
  logic avs_waitrequest, irq, desc_ready, buf_rd_req, buf_rd_done;
  logic hdr_valid, pkt_end, mem_wr_req, mem_wr_ack, next_valid, ctx_stop;
  logic tx_done_irq;
  logic [5:0] desc_step;
  logic [15:0] buf_rd_len, rl;
  logic [31:0] avs_readdata, buf_rd_addr, hdr_q0, hdr_q1, mem_wr_addr;
  logic [31:0] mem_wr_data, next_addr, wa, wd, ra, h0, h1;
  logic [3:0] next_count;
  logic [7:0] wn, irqs = 0;
  int fail_count = 0, check_count = 0, cyc = 0;
  itld_row_t rows [4];
  wire [2:0] ev = {next_valid | ctx_stop | (is_mark & mem_wr_ack),
    next_valid, desc_ready};
  itld_decode i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .desc_valid(desc_valid), .desc_addr(desc_addr),
    .desc_first(desc_first), .desc_q0(desc_q0), .desc_q1(desc_q1),
    .desc_q2(desc_q2), .desc_q3(32'h0000_0000), .desc_imm0(desc_imm0),
    .desc_imm1(desc_imm1), .desc_ready(desc_ready), .desc_step(desc_step),
    .missed_cycle(missed_cycle), .channel_ctrl_word(16'ha5c3),
    .bus_time_seconds(7'h0d), .bus_time_ticks(13'h1234),
    .buf_rd_req(buf_rd_req), .buf_rd_addr(buf_rd_addr),
    .buf_rd_len(buf_rd_len), .buf_rd_done(buf_rd_done),
    .hdr_valid(hdr_valid), .hdr_q0(hdr_q0), .hdr_q1(hdr_q1),
    .pkt_end(pkt_end), .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack),
    .next_valid(next_valid), .next_addr(next_addr),
    .next_count(next_count), .ctx_stop(ctx_stop),
    .tx_done_irq(tx_done_irq));
  itld_host_mem i_mem (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
    .buf_rd_req(buf_rd_req), .mem_wr_req(mem_wr_req),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .buf_rd_done(buf_rd_done), .mem_wr_ack(mem_wr_ack), .last_addr(wa),
    .last_data(wd), .wr_total(wn));
  // ==========================================
  // Clock, timeout and monitors
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  always @(posedge clk_sys) begin
    if (tx_done_irq === 1'b1) irqs <= irqs + 8'h01;
    if (buf_rd_req === 1'b1) {ra, rl} <= {buf_rd_addr, buf_rd_len};
    if (hdr_valid === 1'b1) {h0, h1} <= {hdr_q0, hdr_q1};
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_ev(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ev[k] !== 1'b1 && n < 80);
    if (n == 80) fail_count++;
  endtask
  task automatic run_row(input int r);
    logic [7:0] w0;
    w0 = wn;
    slow <= r[0];
    is_mark <= rows[r].q0[31:28] == 4'h8;
    desc_first <= r == 0;
    desc_addr <= 32'h0000_2000 + r * 32;
    desc_imm0 <= ~rows[r].q0;
    desc_imm1 <= rows[r].q1 ^ 32'h5a5a_5a5a;
    {desc_q0, desc_q1, desc_q2} <= {rows[r].q0, rows[r].q1, rows[r].q2};
    desc_valid <= 1'b1;
    wait_ev(0);
    desc_valid <= 1'b0;
    chk(desc_step, rows[r].step);
    wait_ev(2);
    chk(wn - w0, rows[r].wr);
    if (rows[r].wr != 0) begin
      chk(wa, rows[r].wa);
      chk(wd, rows[r].wd);
    end
    if (rows[r].q0[31:28] == 4'h1 && rows[r].q0[26:24] == 3'h0) begin
      chk(ra, rows[r].q1);
      chk(rl, rows[r].q0[15:0]);
    end
    if (rows[r].q0[26:24] == 3'h1) begin
      chk(h0, ~rows[r].q0);
      chk(h1, rows[r].q1 ^ 32'h5a5a_5a5a);
    end
    if (rows[r].q2[3:0] != 4'h0 && !is_mark) begin
      chk(next_addr, {rows[r].q2[31:4], 4'h0});
      chk(next_count, rows[r].q2[3:0]);
    end else if (!is_mark)
      chk(ctx_stop, 1'b1);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rows[0] = '{32'h8600_beef, 32'h0000_4007, 32'h0000_1233, 32'h0000_4004,
      32'h0000_beef, 6'h10, 8'h01};
    rows[1] = '{32'h183c_0040, 32'h0000_5003, 32'h0000_3002, 32'h0000_202c,
      32'ha5c3_b234, 6'h10, 8'h01};
    rows[2] = '{32'h100c_0010, 32'h0000_6000, 32'h0000_4001, 32'h0000_0000,
      32'h0000_0000, 6'h10, 8'h00};
    rows[3] = '{32'h190c_0008, 32'h0000_0000, 32'h0000_0000, 32'h0000_206c,
      32'ha5c3_b234, 6'h20, 8'h01};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(0, 5'h08, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(0, 5'h14, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1, 5'h08, 32'h0000_0001, q);
    bus(1, 5'h00, 32'h0000_0001, q);
    for (int r = 0; r < 4; r++) run_row(r);
    bus(0, 5'h04, 32'h0000_0000, q);
    chk(q[3:0], 4'h3);
    chk(irq, 1'b1);
    chk(irqs, 8'h01);
    bus(0, 5'h00, 32'h0000_0000, q);
    chk(q[0], 1'b0);
    bus(1, 5'h04, 32'h0000_0001, q);
    bus(0, 5'h08, 32'h0000_0000, q);
    chk(irq, 1'b0);
    @(posedge clk_sys);
    desc_valid <= 1'b1;
    repeat (4) begin
      @(posedge clk_sys);
      chk(desc_ready, 1'b0);
    end
    desc_valid <= 1'b0;
    bus(1, 5'h00, 32'h0000_0001, q);
    @(posedge clk_sys);
    missed_cycle <= 1'b1;
    @(posedge clk_sys);
    missed_cycle <= 1'b0;
    wait_ev(1);
    chk(next_addr, 32'h0000_1230);
    chk(next_count, 4'h3);
    desc_q0 <= 32'h2000_0000;
    desc_valid <= 1'b1;
    wait_ev(0);
    desc_valid <= 1'b0;
    bus(0, 5'h04, 32'h0000_0000, q);
    chk(q[3:0], 4'he);
    bus(0, 5'h0c, 32'h0000_0000, q);
    chk(q, 32'h0000_1230);
    bus(0, 5'h10, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    close_out();
  end
endmodule // itld_decode_test
